// file: src/uspc_pkg.sv
// Constants, types and register map for the port switch configuration bank.
// Assumes a byte-wide register port driven by an on-chip serial bus engine.
package uspc_pkg;
  // Register offsets
  localparam logic [7:0] USPC_ADDR_PORT1_CFG = 8'h11;
  localparam logic [7:0] USPC_ADDR_PORT2_CFG = 8'h12;
  localparam logic [7:0] USPC_ADDR_GLOBAL_CFG = 8'h13;
  localparam logic [7:0] USPC_ADDR_LIMIT = 8'h14;
  // Field positions
  localparam int USPC_BIT_FILTER = 7;
  localparam int USPC_BIT_FORCE = 5;
  localparam int USPC_BIT_SWON = 4;
  localparam int USPC_BIT_DUR_LO = 2;
  localparam int USPC_BIT_AUTO = 2;
  localparam int USPC_BIT_PINIGN = 7;
  localparam int USPC_BIT_TOOFF = 5;
  localparam int USPC_BIT_HILOAD = 2;
  localparam int USPC_BIT_LIM2_LO = 3;
  // Writable masks and fixed read values of unimplemented bits
  localparam logic [7:0] USPC_WMASK_P1 = 8'hBC;
  localparam logic [7:0] USPC_WMASK_P2 = 8'hB4;
  localparam logic [7:0] USPC_WMASK_GL = 8'hA0;
  localparam logic [7:0] USPC_WMASK_LIM = 8'h3F;
  localparam logic [7:0] USPC_FIXED_P1 = 8'h02;
  localparam logic [7:0] USPC_FIXED_P2 = 8'h02;
  localparam logic [7:0] USPC_FIXED_GL = 8'h40;
  // Reset values
  localparam logic [7:0] USPC_RST_P1 = 8'h04;
  localparam logic [7:0] USPC_RST_P2 = 8'h00;
  localparam logic [7:0] USPC_RST_GL = 8'h20;
  // Timing
  localparam int USPC_CLK_MHZ = 100;
  localparam int USPC_DRAIN_STEP_MS = 100;
  localparam int USPC_RETRY_BASE_MS = 10;
  localparam int USPC_RETRY_STEP_MS = 5;
  localparam int USPC_CYC_PER_MS = USPC_CLK_MHZ * 1000;
  localparam logic [25:0] USPC_DRAIN_STEP_CYC = 26'(USPC_DRAIN_STEP_MS * USPC_CYC_PER_MS);
  localparam logic [25:0] USPC_RETRY_BASE_CYC = 26'(USPC_RETRY_BASE_MS * USPC_CYC_PER_MS);
  localparam logic [25:0] USPC_RETRY_STEP_CYC = 26'(USPC_RETRY_STEP_MS * USPC_CYC_PER_MS);
  // Recovery sequence states
  typedef enum logic [1:0] {
    USPC_REC_IDLE = 2'b00,
    USPC_REC_CHECK = 2'b01,
    USPC_REC_TEST = 2'b10
  } uspc_rec_t;
  // Per-port live condition inputs
  typedef struct packed {
    logic overcurrent;
    logic thermal;
    logic other_event;
    logic high_load_indicator;
    logic vbus_low;
    logic safe_to_retry;
    logic error_req;
    logic manual_load;
  } uspc_port_in_t;
  // Per-port control outputs
  typedef struct packed {
    logic switch_on;
    logic drain_on;
    logic fault;
    logic test_current;
    logic drain_check;
    logic [2:0] limit_code;
  } uspc_port_out_t;
  // Per-port dynamic state
  typedef struct packed {
    uspc_rec_t rec;
    logic [25:0] tmr;
    logic drain_act;
    logic force_prev;
    logic error;
  } uspc_port_st_t;
  // Whole block state
  typedef struct packed {
    logic [7:0] p1_cfg;
    logic [7:0] p2_cfg;
    logic [7:0] gl_cfg;
    logic [7:0] lim;
    logic [1:0] strap_cnt; // Edges since reset, stops at 3 once strap is loaded
    logic [7:0] rdata;
    uspc_port_st_t [1:0] port;
    uspc_port_out_t [1:0] out;
    logic [1:0] pin_s1;
    logic [1:0] pin_s2;
    logic [2:0] strap_s1;
    logic [2:0] strap_s2;
    logic timeout_off;
    logic [1:0] view;
  } uspc_state_t;
endpackage : uspc_pkg

// file: src/uspc_config_regs.sv
// Configuration register bank and per-port switch control.
// Assumes a byte register port from the serial bus engine, same clock.
`timescale 1ns/1ps
`default_nettype none
module uspc_config_regs
  import uspc_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic [1:0] power_pin_i,
  input wire logic [2:0] limit_select_resistor_pin_i,
  input wire logic [1:0] retry_duration_sel_i,
  input wire logic sleep_i,
  input wire uspc_port_in_t port1_i,
  input wire uspc_port_in_t port2_i,
  output uspc_port_out_t port1_o,
  output uspc_port_out_t port2_o,
  output logic bus_timeout_off_o,
  output logic [1:0] port_power_state_view_o
);
  uspc_state_t s_r; // Registered state
  uspc_state_t s_nxt; // Next state
  uspc_port_in_t pin_in [2]; // Port inputs as array
  logic [7:0] cfg_cur; // Port config in loop
  logic en_eff; // Effective enable in loop
  logic auto_on; // Automatic drain enabled
  logic [2:0] code; // Limit code in loop

  // Drain duration in cycles for a two-bit code
  function automatic logic [25:0] drain_cycles(input logic [1:0] sel);
    drain_cycles = 26'(USPC_DRAIN_STEP_CYC * (26'(sel) + 26'd1));
  endfunction : drain_cycles

  // Retry duration in cycles for a two-bit code
  function automatic logic [25:0] retry_cycles(input logic [1:0] sel);
    retry_cycles = 26'(USPC_RETRY_BASE_CYC + USPC_RETRY_STEP_CYC * 26'(sel));
  endfunction : retry_cycles

  // Cap a code at the strap limit
  function automatic logic [2:0] cap_code(input logic [2:0] c, input logic [2:0] cap);
    cap_code = (c > cap) ? cap : c;
  endfunction : cap_code

  assign pin_in[0] = port1_i;
  assign pin_in[1] = port2_i;

  // Next-state logic
  always_comb
  begin
    s_nxt = s_r;
    cfg_cur = 8'h00;
    en_eff = 1'b0;
    code = 3'b000;
    auto_on = s_r.p2_cfg[USPC_BIT_AUTO];
    // Pin and strap synchronisers
    s_nxt.pin_s1 = power_pin_i;
    s_nxt.pin_s2 = s_r.pin_s1;
    s_nxt.strap_s1 = limit_select_resistor_pin_i;
    s_nxt.strap_s2 = s_r.strap_s1;
    // Limit register takes the strap once after reset
    // Synchroniser holds zeros after reset, so wait until it is full
    if (s_r.strap_cnt != 2'h3)
    begin
      s_nxt.strap_cnt = s_r.strap_cnt + 2'h1;
      if (s_r.strap_cnt == 2'h2)
        s_nxt.lim = {2'b00, s_r.strap_s2, s_r.strap_s2};
    end
    // Register writes; sleep leaves all settings untouched
    if (reg_wr_i)
    begin
      case (reg_addr_i)
        USPC_ADDR_PORT1_CFG: s_nxt.p1_cfg = reg_wdata_i & USPC_WMASK_P1;
        USPC_ADDR_PORT2_CFG: s_nxt.p2_cfg = reg_wdata_i & USPC_WMASK_P2;
        USPC_ADDR_GLOBAL_CFG:
        begin
          // High_load_indicator bit is status only
          s_nxt.gl_cfg = (reg_wdata_i & USPC_WMASK_GL) | (s_r.gl_cfg & ~USPC_WMASK_GL);
        end
        USPC_ADDR_LIMIT:
        begin
          s_nxt.lim = {2'b00,
                       cap_code(reg_wdata_i[5:3], s_r.strap_s2),
                       cap_code(reg_wdata_i[2:0], s_r.strap_s2)};
        end
        default: ; // Other addresses belong elsewhere
      endcase
    end
    // High_load_indicator indicator is live status
    s_nxt.gl_cfg[USPC_BIT_HILOAD] = port1_i.high_load_indicator | port2_i.high_load_indicator;
    s_nxt.timeout_off = s_r.gl_cfg[USPC_BIT_TOOFF];
    // Register read mux
    if (reg_rd_i)
    begin
      case (reg_addr_i)
        USPC_ADDR_PORT1_CFG: s_nxt.rdata = s_r.p1_cfg | USPC_FIXED_P1;
        USPC_ADDR_PORT2_CFG: s_nxt.rdata = s_r.p2_cfg | USPC_FIXED_P2;
        USPC_ADDR_GLOBAL_CFG: s_nxt.rdata = s_r.gl_cfg | USPC_FIXED_GL;
        USPC_ADDR_LIMIT: s_nxt.rdata = s_r.lim;
        default: s_nxt.rdata = 8'h00;
      endcase
    end
    // Per-port control
    for (int p = 0; p < 2; p++)
    begin
      cfg_cur = (p == 0) ? s_r.p1_cfg : s_r.p2_cfg;
      code = (p == 0) ? s_r.lim[2:0] : s_r.lim[5:3];
      // Enable from pin and override, pins optionally disregarded
      en_eff = cfg_cur[USPC_BIT_SWON] |
               (s_r.pin_s2[p] & ~s_r.gl_cfg[USPC_BIT_PINIGN]);
      s_nxt.view[p] = s_r.pin_s2[p] | cfg_cur[USPC_BIT_SWON];
      s_nxt.port[p].force_prev = cfg_cur[USPC_BIT_FORCE];
      // Forced drain on rising bit, only with auto drain and active state
      if (cfg_cur[USPC_BIT_FORCE] && !s_r.port[p].force_prev && auto_on &&
          !s_r.port[p].error && !sleep_i)
      begin
        s_nxt.port[p].drain_act = 1'b1;
        s_nxt.port[p].tmr = drain_cycles(s_r.p1_cfg[3:2]);
      end
      else if (s_r.port[p].drain_act)
      begin
        if (s_r.port[p].tmr <= 26'd1)
          s_nxt.port[p].drain_act = 1'b0; // Bit stays set for host
        else
          s_nxt.port[p].tmr = s_r.port[p].tmr - 26'd1;
      end
      // Error entry and auto-recovery sequence
      case (s_r.port[p].rec)
        USPC_REC_IDLE:
        begin
          if (pin_in[p].error_req)
          begin
            s_nxt.port[p].error = 1'b1;
            s_nxt.port[p].rec = USPC_REC_CHECK;
          end
        end
        USPC_REC_CHECK:
        begin
          if (pin_in[p].safe_to_retry && !s_r.port[p].drain_act)
          begin
            s_nxt.port[p].rec = USPC_REC_TEST;
            s_nxt.port[p].tmr = retry_cycles(retry_duration_sel_i);
          end
        end
        USPC_REC_TEST:
        begin
          if (s_r.port[p].tmr <= 26'd1)
          begin
            if (pin_in[p].vbus_low)
              s_nxt.port[p].rec = USPC_REC_CHECK;
            else
            begin
              s_nxt.port[p].rec = USPC_REC_IDLE;
              s_nxt.port[p].error = 1'b0;
            end
          end
          else
            s_nxt.port[p].tmr = s_r.port[p].tmr - 26'd1;
        end
        default: s_nxt.port[p].rec = USPC_REC_IDLE;
      endcase
      // Output controls
      s_nxt.out[p].test_current = (s_r.port[p].rec == USPC_REC_TEST);
      s_nxt.out[p].switch_on = (s_r.port[p].rec == USPC_REC_TEST) ||
                               (en_eff && !s_r.port[p].error &&
                                !s_r.port[p].drain_act);
      s_nxt.out[p].drain_on = auto_on ? s_r.port[p].drain_act
                                      : pin_in[p].manual_load;
      s_nxt.out[p].drain_check = auto_on & s_r.port[p].drain_act;
      s_nxt.out[p].limit_code = code;
      s_nxt.out[p].fault = pin_in[p].overcurrent | pin_in[p].thermal |
                           (~cfg_cur[USPC_BIT_FILTER] & pin_in[p].other_event);
    end
  end

  // State register; settings held through sleep
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      s_r <= '0;
      s_r.p1_cfg <= USPC_RST_P1;
      s_r.p2_cfg <= USPC_RST_P2;
      s_r.gl_cfg <= USPC_RST_GL;
      s_r.timeout_off <= 1'b1;
    end
    else if (clk_en_i)
      s_r <= s_nxt;
  end

  assign reg_rdata_o = s_r.rdata;
  assign port1_o = s_r.out[0];
  assign port2_o = s_r.out[1];
  assign bus_timeout_off_o = s_r.timeout_off;
  assign port_power_state_view_o = s_r.view;
endmodule : uspc_config_regs
`default_nettype wire

// file: verif/uspc_host_model.sv
// Host model: byte accesses on the register port.
// Assumes the bench calls its tasks; drives 1 ns after rising edges.
`timescale 1ns/1ps
`default_nettype none
module uspc_host_model
(
  input wire logic mclk_i,
  input wire logic [7:0] reg_rdata_i,
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  output logic reg_wr_o,
  output logic reg_rd_o
);
  // Idle bus at time zero
  initial
  begin
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
  end
  // Write held across one sampling edge; data scrambled after
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    #1;
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    @(posedge mclk_i);
    #1;
    reg_wr_o = 1'b0;
    reg_wdata_o = ~d;
  endtask : wr
  // Read; data taken once the strobe edge has passed
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    #1;
    reg_addr_o = a;
    reg_rd_o = 1'b1;
    @(posedge mclk_i);
    #1;
    reg_rd_o = 1'b0;
    d = reg_rdata_i;
  endtask : rd
endmodule : uspc_host_model
`default_nettype wire

// file: verif/uspc_config_regs_chk.sv
// Port checker for the configuration bank.
// Assumes one clock domain; bound onto uspc_config_regs.
`timescale 1ns/1ps
`default_nettype none
module uspc_regs_chk
  import uspc_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [2:0] limit_select_resistor_pin_i,
  input wire logic sleep_i,
  input wire uspc_port_in_t port1_i,
  input wire uspc_port_in_t port2_i,
  input wire uspc_port_out_t port1_o,
  input wire uspc_port_out_t port2_o,
  input wire logic bus_timeout_off_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  logic auto_r; // Shadow of auto drain bit
  logic force_r; // Shadow of port 1 force bit
  logic wr_en; // Write taken this edge
  assign wr_en = clk_en_i && reg_wr_i;
  // Track the two stored bits
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      auto_r <= 1'b0;
      force_r <= 1'b0;
    end
    else if (wr_en)
    begin
      if (reg_addr_i == USPC_ADDR_PORT2_CFG) auto_r <= reg_wdata_i[USPC_BIT_AUTO];
      if (reg_addr_i == USPC_ADDR_PORT1_CFG) force_r <= reg_wdata_i[USPC_BIT_FORCE];
    end
  end
  AST_FAULT1: assert property (clk_en_i && port1_i.overcurrent |=> port1_o.fault)
    else $error("port 1 fault missing");
  AST_FAULT2: assert property (clk_en_i && port2_i.thermal |=> port2_o.fault)
    else $error("port 2 fault missing");
  AST_TOOFF: assert property (wr_en && reg_addr_i == USPC_ADDR_GLOBAL_CFG |->
    ##3 bus_timeout_off_o == $past(reg_wdata_i[USPC_BIT_TOOFF], 3))
    else $error("timeout off output wrong");
  AST_DRAIN_OPEN: assert property (port1_o.drain_check |-> !port1_o.switch_on)
    else $error("switch closed while draining");
  AST_FORCE: assert property (wr_en && reg_addr_i == USPC_ADDR_PORT1_CFG
    && reg_wdata_i[USPC_BIT_FORCE] && !force_r && auto_r && !sleep_i
    |-> ##[1:4] port1_o.drain_on)
    else $error("forced drain did not start");
  AST_NO_AUTO: assert property ($past(clk_en_i && !reset_i && !auto_r)
    |-> port1_o.drain_on == $past(port1_i.manual_load))
    else $error("drain not following manual load with auto off");
  AST_LIM: assert property (port1_o.limit_code <= limit_select_resistor_pin_i
    && port2_o.limit_code <= limit_select_resistor_pin_i)
    else $error("limit above strap");
  AST_RD_NONE: assert property (clk_en_i && reg_rd_i && reg_addr_i == 8'h00
    |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  AST_RD_GL: assert property (clk_en_i && reg_rd_i && reg_addr_i == USPC_ADDR_GLOBAL_CFG
    |=> reg_rdata_o[6] && reg_rdata_o[1:0] == 2'h0)
    else $error("fixed bits of global wrong");
  AST_TEST_ON: assert property (port2_o.test_current |-> port2_o.switch_on)
    else $error("test current without switch");
  COV_DRAIN: cover property (port1_o.drain_on);
  COV_TEST: cover property (port2_o.test_current);
  COV_FAULT: cover property (port1_o.fault);
  COV_MANUAL: cover property (port1_o.drain_on && !port1_o.drain_check);
endmodule : uspc_regs_chk
bind uspc_config_regs uspc_regs_chk chk_u (.mclk_i, .reset_i, .clk_en_i, .reg_addr_i,
  .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .limit_select_resistor_pin_i,
  .sleep_i, .port1_i, .port2_i, .port1_o, .port2_o, .bus_timeout_off_o);
`default_nettype wire

// file: verif/usb_port_switch_config_regs_tb.sv
// Self-checking bench for the configuration bank.
// Assumes the host model drives the register port.
`timescale 1ns/1ps
`default_nettype none
module usb_port_switch_config_regs_tb
  import uspc_pkg::*;
;
  localparam logic [2:0] STRAP = 3'h5; // Strap cap code
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] addr, wdata, rdata;
  logic wr, rd, tout;
  logic sleep = 1'b0;
  logic clk_en = 1'b1; // Low freezes the whole bank
  logic [1:0] pins = 2'h0;
  logic [1:0] view;
  uspc_port_in_t p1 = '0;
  uspc_port_in_t p2 = '0;
  uspc_port_out_t o1, o2;
  int miscompares = 0;
  int n_compared = 0;
  int cycles = 0;
  uspc_config_regs dut_u (.mclk_i(mclk_i), .reset_i(reset_i), .clk_en_i(clk_en),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .power_pin_i(pins), .limit_select_resistor_pin_i(STRAP),
    .retry_duration_sel_i(2'h0), .sleep_i(sleep), .port1_i(p1), .port2_i(p2),
    .port1_o(o1), .port2_o(o2), .bus_timeout_off_o(tout), .port_power_state_view_o(view));
  uspc_host_model host_u (.mclk_i(mclk_i), .reg_rdata_i(rdata), .reg_addr_o(addr),
    .reg_wdata_o(wdata), .reg_wr_o(wr), .reg_rd_o(rd));
  initial
  begin
    forever #5 mclk_i = ~mclk_i;
  end
  // Hang guard
  always @(posedge mclk_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("compared=%0d miscompares=%0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host_u.rd(a, d);
    chk(d, exp);
  endtask : rchk
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : cyc
  // Reset values and fixed bits
  task automatic t_reset();
    rchk(USPC_ADDR_PORT1_CFG, 8'h06);
    rchk(USPC_ADDR_PORT2_CFG, 8'h02);
    rchk(USPC_ADDR_GLOBAL_CFG, 8'h60);
    rchk(USPC_ADDR_LIMIT, {2'h0, STRAP, STRAP});
    chk({7'h00, tout}, 8'h01);
  endtask : t_reset
  // Masks, clamp, sleep, unmapped, timeout bit
  task automatic t_regs();
    host_u.wr(USPC_ADDR_PORT1_CFG, 8'hFF);
    p1.manual_load = 1'b1;
    cyc(3);
    rchk(USPC_ADDR_PORT1_CFG, 8'hBE);
    chk({5'h00, o1.drain_check, o1.drain_on, o1.switch_on}, 8'h03);
    p1.manual_load = 1'b0;
    host_u.wr(USPC_ADDR_PORT1_CFG, 8'h00);
    host_u.wr(USPC_ADDR_LIMIT, 8'hFF);
    rchk(USPC_ADDR_LIMIT, 8'h2D);
    host_u.wr(USPC_ADDR_LIMIT, 8'h0A);
    sleep = 1'b1;
    cyc(3);
    rchk(USPC_ADDR_LIMIT, 8'h0A);
    chk({2'h0, o2.limit_code, o1.limit_code}, 8'h0A);
    sleep = 1'b0;
    clk_en = 1'b0;
    host_u.wr(USPC_ADDR_LIMIT, 8'h00);
    clk_en = 1'b1;
    rchk(USPC_ADDR_LIMIT, 8'h0A);
    rchk(8'h00, 8'h00);
    host_u.wr(USPC_ADDR_GLOBAL_CFG, 8'h00);
    cyc(4);
    chk({7'h00, tout}, 8'h00);
  endtask : t_regs
  // Pin OR bit, pin disregard
  task automatic t_pins();
    pins = 2'h2;
    cyc(6);
    chk({5'h00, view, o2.switch_on}, 8'h05);
    host_u.wr(USPC_ADDR_GLOBAL_CFG, 8'hA0);
    cyc(3);
    chk({7'h00, o2.switch_on}, 8'h00);
    pins = 2'h0;
  endtask : t_pins
  // Alert filter and high_load_indicator view
  task automatic t_fault();
    p1.other_event = 1'b1;
    cyc(2);
    chk({7'h00, o1.fault}, 8'h01);
    host_u.wr(USPC_ADDR_PORT1_CFG, 8'h80);
    cyc(3);
    chk({7'h00, o1.fault}, 8'h00);
    p1.overcurrent = 1'b1;
    p2.thermal = 1'b1;
    p2.high_load_indicator = 1'b1;
    cyc(2);
    chk({6'h00, o1.fault, o2.fault}, 8'h03);
    rchk(USPC_ADDR_GLOBAL_CFG, 8'hE4);
    p1 = '0;
    p2 = '0;
  endtask : t_fault
  // Forced drain, bit left for the host
  task automatic t_drain();
    host_u.wr(USPC_ADDR_PORT2_CFG, 8'h04);
    p2.manual_load = 1'b1;
    host_u.wr(USPC_ADDR_PORT1_CFG, 8'h2C);
    cyc(3);
    chk({5'h00, o1.drain_check, o1.drain_on, o1.switch_on}, 8'h06);
    chk({7'h00, o2.drain_on}, 8'h00);
    p2.manual_load = 1'b0;
    rchk(USPC_ADDR_PORT1_CFG, 8'h2E);
    host_u.wr(USPC_ADDR_PORT1_CFG, 8'h0C);
  endtask : t_drain
  // Recovery test phase
  task automatic t_recover();
    p2.error_req = 1'b1;
    p2.safe_to_retry = 1'b1;
    cyc(1);
    p2.error_req = 1'b0;
    cyc(4);
    chk({5'h00, o1.test_current, o2.test_current, o2.switch_on}, 8'h03);
  endtask : t_recover
  initial
  begin
    cyc(2);
    reset_i = 1'b0;
    cyc(3);
    t_reset();
    t_regs();
    t_pins();
    t_fault();
    t_drain();
    t_recover();
    end_sim();
  end
endmodule : usb_port_switch_config_regs_tb
`default_nettype wire
